// >>> design/dtmc_pin_sync.sv
// three-stage synchroniser with falling-edge detect for one pin
// assumes the pin is asynchronous to core_clk
`timescale 1ns/1ns
module dtmc_pin_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pin side
	input wire logic pinIn,
	// core side
	output logic level,
	output logic fall
);
	logic s1_r, s2_r, s3_r, level_r, fall_r;
	logic level_nxt, fall_nxt;

	// ==========================================
	// filtered level: only moves when stages two and three agree
	always_comb begin
		level_nxt = level_r;
		fall_nxt = 1'b0;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
			fall_nxt = level_r & ~s3_r; // one pulse per high-to-low
		end
	end

	// stage one is read by stage two only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			level_r <= 1'b1;
			fall_r <= 1'b0;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign level = level_r;
	assign fall = fall_r;
endmodule : dtmc_pin_sync

// >>> design/dtmc_pkg.sv
// constants for the dual timer mode configuration block
// assumes one core clock; software reaches the registers through a byte-wide register port
package dtmc_pkg;
	// ==========================================
	// register selects on the register port
	localparam logic [2:0] SEL_MODE = 3'h0;
	localparam logic [2:0] SEL_T0LO = 3'h1;
	localparam logic [2:0] SEL_T0HI = 3'h2;
	localparam logic [2:0] SEL_T1LO = 3'h3;
	localparam logic [2:0] SEL_T1HI = 3'h4;
	// ==========================================
	// mode register fields and reset value
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int T0_MODE_LSB = 0;
	localparam int T0_SRC_BIT = 2;
	localparam int T0_GATE_BIT = 3;
	localparam int T1_MODE_LSB = 4;
	localparam int T1_SRC_BIT = 6;
	localparam int T1_GATE_BIT = 7;
	localparam logic [4:0] M13_LOW_FULL = 5'h1f;
	localparam logic [7:0] BYTE_FULL = 8'hff;
	// ==========================================
	// operating modes
	typedef enum logic [1:0] {
		MODE_13BIT = 2'h0,
		MODE_16BIT = 2'h1,
		MODE_8RELOAD = 2'h2,
		MODE_SPLIT = 2'h3
	} dtmc_mode_t;
endpackage : dtmc_pkg

// >>> design/dtmc_timer.sv
// two counter/timers with their shared mode register
// assumes run bits and clock ticks come from core_clk logic; pins are asynchronous
// Notes on behaviour
// - gate off counts on run bit alone; gate on also needs irq pin high
// - timer 0 mode is mode register bits 1 and 0
// - timer 0 modes 00 13-bit, 01 16-bit, 10 8-bit auto-reload
// - timer 1 mode in bits 5-4; 10 is 8-bit auto-reload
// - timer 1 mode 11 stops timer 1 regardless of its run bit
// - timer 0 split: low byte own controls, high byte on timer 1 run, sets its flag
// - during split timer 1 runs by mode only, internal clock, no flag, trigger kept
`timescale 1ns/1ns
module dtmc_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic sfrWe,
	input wire logic [2:0] sfrSel,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	// run bits and internal ticks
	input wire logic timer0_run,
	input wire logic timer1_run,
	input wire logic timer0Tick,
	input wire logic timer1Tick,
	// pins
	input wire logic ext_irq0_pin_n,
	input wire logic ext_irq1_pin_n,
	input wire logic timer0_count_input,
	input wire logic timer1_count_input,
	// events
	output logic timer0OvfSet,
	output logic timer1OvfSet,
	output logic timer1Trigger
);
	logic [7:0] modeCfg_r, modeCfg_nxt;
	logic [7:0] timer0_low_byte_r, timer0_low_byte_nxt, timer0_high_byte_r, timer0_high_byte_nxt;
	logic [7:0] t1Lo_r, t1Lo_nxt, t1Hi_r, t1Hi_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic ovf0_r, ovf0_nxt, ovf1_r, ovf1_nxt, trig_r, trig_nxt;
	logic irq0Lvl, irq1Lvl, cnt0Fall, cnt1Fall;
	logic [1:0] t0Mode, t1Mode;
	logic t0Split, t0En, t1En, inc0, inc1, incHi0;
	logic [16:0] step0, step1;

	// ==========================================
	// pin synchronisers
	dtmc_pin_sync uIrq0 (.core_clk(core_clk), .rst(rst), .pinIn(ext_irq0_pin_n),
		.level(irq0Lvl), .fall());
	dtmc_pin_sync uIrq1 (.core_clk(core_clk), .rst(rst), .pinIn(ext_irq1_pin_n),
		.level(irq1Lvl), .fall());
	dtmc_pin_sync uCnt0 (.core_clk(core_clk), .rst(rst), .pinIn(timer0_count_input),
		.level(), .fall(cnt0Fall));
	dtmc_pin_sync uCnt1 (.core_clk(core_clk), .rst(rst), .pinIn(timer1_count_input),
		.level(), .fall(cnt1Fall));

	// ==========================================
	// one increment of a timer pair; result is {overflow, high, low}
	function automatic logic [16:0] stepPair(input logic [7:0] hi, input logic [7:0] lo,
			input logic [1:0] mode);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (mode)
			dtmc_pkg::MODE_13BIT: begin
				// upper three bits of the low byte are left alone
				if (lo[4:0] == dtmc_pkg::M13_LOW_FULL) begin
					r = {(hi == dtmc_pkg::BYTE_FULL), 8'(hi + 8'h01), lo[7:5], 5'h00};
				end else begin
					r = {1'b0, hi, lo[7:5], 5'(lo[4:0] + 5'h01)};
				end
			end
			dtmc_pkg::MODE_16BIT: begin
				r = 17'({1'b0, hi, lo} + 17'h00001);
			end
			dtmc_pkg::MODE_8RELOAD: begin
				if (lo == dtmc_pkg::BYTE_FULL) begin
					r = {1'b1, hi, hi};
				end else begin
					r = {1'b0, hi, 8'(lo + 8'h01)};
				end
			end
			default: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction : stepPair

	// ==========================================
	// mode decode and count enables
	always_comb begin
		t0Mode = modeCfg_r[dtmc_pkg::T0_MODE_LSB +: 2];
		t1Mode = modeCfg_r[dtmc_pkg::T1_MODE_LSB +: 2];
		t0Split = (t0Mode == dtmc_pkg::MODE_SPLIT);
		t0En = timer0_run & (~modeCfg_r[dtmc_pkg::T0_GATE_BIT] | irq0Lvl);
		t1En = timer1_run & (~modeCfg_r[dtmc_pkg::T1_GATE_BIT] | irq1Lvl);
		inc0 = t0En & (modeCfg_r[dtmc_pkg::T0_SRC_BIT] ? cnt0Fall : timer0Tick);
		// high byte in split mode is a pure timer on the internal tick
		incHi0 = t0Split & timer1_run & timer0Tick;
		if (t1Mode == dtmc_pkg::MODE_SPLIT) begin
			inc1 = 1'b0;
		end else if (t0Split) begin
			inc1 = timer1Tick;
		end else begin
			inc1 = t1En & (modeCfg_r[dtmc_pkg::T1_SRC_BIT] ? cnt1Fall : timer1Tick);
		end
		step0 = stepPair(timer0_high_byte_r, timer0_low_byte_r, t0Mode);
		step1 = stepPair(t1Hi_r, t1Lo_r, t1Mode);
	end

	// ==========================================
	// counters, events and register writes; a write wins over a count in the same cycle
	always_comb begin
		modeCfg_nxt = modeCfg_r;
		timer0_low_byte_nxt = timer0_low_byte_r;
		timer0_high_byte_nxt = timer0_high_byte_r;
		t1Lo_nxt = t1Lo_r;
		t1Hi_nxt = t1Hi_r;
		ovf0_nxt = 1'b0;
		ovf1_nxt = 1'b0;
		trig_nxt = 1'b0;
		if (t0Split) begin
			if (inc0) begin
				timer0_low_byte_nxt = 8'(timer0_low_byte_r + 8'h01);
				ovf0_nxt = (timer0_low_byte_r == dtmc_pkg::BYTE_FULL);
			end
			if (incHi0) begin
				timer0_high_byte_nxt = 8'(timer0_high_byte_r + 8'h01);
				ovf1_nxt = (timer0_high_byte_r == dtmc_pkg::BYTE_FULL);
			end
		end else if (inc0) begin
			{ovf0_nxt, timer0_high_byte_nxt, timer0_low_byte_nxt} = step0;
		end
		if (inc1) begin
			{trig_nxt, t1Hi_nxt, t1Lo_nxt} = step1;
			// trigger still serves converters and baud logic during split
			if (!t0Split) begin
				ovf1_nxt = step1[16];
			end
		end
		if (sfrWe) begin
			case (sfrSel)
				dtmc_pkg::SEL_MODE: modeCfg_nxt = sfrWdata;
				dtmc_pkg::SEL_T0LO: timer0_low_byte_nxt = sfrWdata;
				dtmc_pkg::SEL_T0HI: timer0_high_byte_nxt = sfrWdata;
				dtmc_pkg::SEL_T1LO: t1Lo_nxt = sfrWdata;
				dtmc_pkg::SEL_T1HI: t1Hi_nxt = sfrWdata;
				default: modeCfg_nxt = modeCfg_r;
			endcase
		end
		case (sfrSel)
			dtmc_pkg::SEL_MODE: rdata_nxt = modeCfg_nxt;
			dtmc_pkg::SEL_T0LO: rdata_nxt = timer0_low_byte_nxt;
			dtmc_pkg::SEL_T0HI: rdata_nxt = timer0_high_byte_nxt;
			dtmc_pkg::SEL_T1LO: rdata_nxt = t1Lo_nxt;
			dtmc_pkg::SEL_T1HI: rdata_nxt = t1Hi_nxt;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modeCfg_r <= dtmc_pkg::MODE_RESET;
			timer0_low_byte_r <= 8'h00;
			timer0_high_byte_r <= 8'h00;
			t1Lo_r <= 8'h00;
			t1Hi_r <= 8'h00;
			rdata_r <= 8'h00;
			ovf0_r <= 1'b0;
			ovf1_r <= 1'b0;
			trig_r <= 1'b0;
		end else begin
			modeCfg_r <= modeCfg_nxt;
			timer0_low_byte_r <= timer0_low_byte_nxt;
			timer0_high_byte_r <= timer0_high_byte_nxt;
			t1Lo_r <= t1Lo_nxt;
			t1Hi_r <= t1Hi_nxt;
			rdata_r <= rdata_nxt;
			ovf0_r <= ovf0_nxt;
			ovf1_r <= ovf1_nxt;
			trig_r <= trig_nxt;
		end
	end

	assign sfrRdata = rdata_r;
	assign timer0OvfSet = ovf0_r;
	assign timer1OvfSet = ovf1_r;
	assign timer1Trigger = trig_r;

	// ==========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	gate_blocks_count_a: assert property (modeCfg_r[3] && !irq0Lvl && !sfrWe |=>
		$stable(timer0_low_byte_r)) else $error("gated timer 0 counted");
	run_alone_counts_a: assert property (!modeCfg_r[3] && !modeCfg_r[2] && timer0_run
		&& timer0Tick && modeCfg_r[1:0] == 2'h1 && !sfrWe |=>
		timer0_low_byte_r == 8'($past(timer0_low_byte_r) + 8'h01))
		else $error("ungated timer 0 did not count");
	// a mode write must land in the two lowest bits of the timer 0 field
	mode0_field_a: assert property (sfrWe && sfrSel == 3'h0 |=>
		{6'h00, t0Mode} == ($past(sfrWdata) & 8'h03))
		else $error("timer 0 mode field wrong");
	m13_carry_a: assert property (t0Mode == 2'h0 && inc0 && timer0_low_byte_r[4:0] == 5'h1f
		&& !sfrWe |=> timer0_low_byte_r[4:0] == 5'h00 &&
		timer0_high_byte_r == 8'($past(timer0_high_byte_r) + 8'h01))
		else $error("13-bit carry wrong");
	t1_reload_a: assert property (t1Mode == 2'h2 && inc1 && t1Lo_r == 8'hff && !sfrWe |=>
		t1Lo_r == t1Hi_r && timer1Trigger) else $error("timer 1 reload wrong");
	t1_idle_a: assert property (t1Mode == 2'h3 && !sfrWe |=>
		$stable(t1Lo_r) && $stable(t1Hi_r) && !timer1Trigger)
		else $error("timer 1 counted in mode 3");
	split_high_ovf_a: assert property (t0Split && timer1_run && timer0Tick &&
		timer0_high_byte_r == 8'hff && !sfrWe |=> timer1OvfSet && timer0_high_byte_r == 8'h00)
		else $error("split high byte overflow lost");
	// timer 1 overflows during split: trigger pulses but the flag stays quiet
	split_t1_noflag_a: assert property (t0Split && !incHi0 && inc1 && t1Mode == 2'h2
		&& t1Lo_r == 8'hff && !sfrWe |=> !timer1OvfSet && timer1Trigger)
		else $error("timer 1 set its flag during split");
	split_t1_runs_a: assert property (t0Split && t1Mode == 2'h2 && !timer1_run && timer1Tick
		&& t1Lo_r != 8'hff && !sfrWe |=> t1Lo_r == 8'($past(t1Lo_r) + 8'h01))
		else $error("timer 1 did not run during split");
	ext_source_a: assert property (modeCfg_r[2] && !cnt0Fall && !sfrWe |=>
		$stable(timer0_low_byte_r)) else $error("counter mode counted without edge");

	split_mode_c: cover property (timer1OvfSet && t0Split);
	reload_c: cover property (timer0OvfSet && t0Mode == 2'h2);
	ext_count_c: cover property (inc0 && modeCfg_r[2]);
endmodule : dtmc_timer

// >>> test/tb_top.sv
// self-checking bench for the dual timer mode configuration block
// assumes dtmc_timer alone; every input is driven by the bench at the falling edge
`timescale 1ns/1ns
module tb_top;
	// ==========================================
	// stimulus and observed signals
	logic core_clk, rst, sfrWe, timer0_run, timer1_run, timer0Tick, timer1Tick;
	logic ext_irq0_pin_n, ext_irq1_pin_n, timer0_count_input, timer1_count_input;
	logic timer0OvfSet, timer1OvfSet, timer1Trigger;
	logic [2:0] sfrSel;
	logic [7:0] sfrWdata, sfrRdata;
	int fails = 0;
	int samplesChecked = 0;

	dtmc_timer uut (.core_clk(core_clk), .rst(rst), .sfrWe(sfrWe), .sfrSel(sfrSel),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .timer0_run(timer0_run),
		.timer1_run(timer1_run), .timer0Tick(timer0Tick), .timer1Tick(timer1Tick),
		.ext_irq0_pin_n(ext_irq0_pin_n), .ext_irq1_pin_n(ext_irq1_pin_n),
		.timer0_count_input(timer0_count_input), .timer1_count_input(timer1_count_input),
		.timer0OvfSet(timer0OvfSet), .timer1OvfSet(timer1OvfSet),
		.timer1Trigger(timer1Trigger));

	// ==========================================
	// 25 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ==========================================
	// shared helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic waitc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : waitc

	// one-cycle write strobe, released at the next falling edge
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		@(negedge core_clk);
		sfrWe = 1'b1;
		sfrSel = s;
		sfrWdata = d;
		@(negedge core_clk);
		sfrWe = 1'b0;
	endtask : wr

	// read data is registered, so it is judged one edge after the select
	task automatic rd(input logic [2:0] s, input logic [7:0] e);
		@(negedge core_clk);
		sfrSel = s;
		@(negedge core_clk);
		chk(sfrRdata, e);
	endtask : rd

	// pulse the ticks for one edge; e holds ovf0, ovf1, trigger
	task automatic step(input logic t0, input logic t1, input logic [2:0] e);
		@(negedge core_clk);
		timer0Tick = t0;
		timer1Tick = t1;
		@(negedge core_clk);
		timer0Tick = 1'b0;
		timer1Tick = 1'b0;
		chk({5'h00, timer0OvfSet, timer1OvfSet, timer1Trigger}, {5'h00, e});
	endtask : step

	// ==========================================
	// scenarios
	task automatic sc_regs();
		rd(dtmc_pkg::SEL_MODE, 8'h00);
		wr(dtmc_pkg::SEL_MODE, 8'ha5);
		rd(dtmc_pkg::SEL_MODE, 8'ha5);
		wr(3'h7, 8'h33); // unmapped select must leave everything alone
		rd(3'h7, 8'h00);
		rd(dtmc_pkg::SEL_MODE, 8'ha5);
	endtask : sc_regs

	task automatic sc_modes();
		timer0_run = 1'b1;
		wr(dtmc_pkg::SEL_MODE, 8'h01);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		wr(dtmc_pkg::SEL_T0HI, 8'hff);
		step(1'b1, 1'b0, 3'h4);
		rd(dtmc_pkg::SEL_T0HI, 8'h00);
		wr(dtmc_pkg::SEL_MODE, 8'h00);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		wr(dtmc_pkg::SEL_T0HI, 8'hff);
		step(1'b1, 1'b0, 3'h4);
		rd(dtmc_pkg::SEL_T0LO, 8'he0);
		wr(dtmc_pkg::SEL_MODE, 8'h02);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		wr(dtmc_pkg::SEL_T0HI, 8'h5a);
		step(1'b1, 1'b0, 3'h4);
		step(1'b1, 1'b0, 3'h0);
		rd(dtmc_pkg::SEL_T0LO, 8'h5b);
	endtask : sc_modes

	task automatic sc_gate();
		wr(dtmc_pkg::SEL_MODE, 8'h0a);
		wr(dtmc_pkg::SEL_T0HI, 8'h00);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		ext_irq0_pin_n = 1'b0;
		waitc(6); // let the pin through the synchroniser
		step(1'b1, 1'b0, 3'h0);
		rd(dtmc_pkg::SEL_T0LO, 8'hff);
		ext_irq0_pin_n = 1'b1;
		waitc(6);
		step(1'b1, 1'b0, 3'h4);
		wr(dtmc_pkg::SEL_MODE, 8'h02);
		ext_irq0_pin_n = 1'b0;
		waitc(6);
		step(1'b1, 1'b0, 3'h0);
		rd(dtmc_pkg::SEL_T0LO, 8'h01);
		ext_irq0_pin_n = 1'b1;
	endtask : sc_gate

	task automatic sc_source();
		wr(dtmc_pkg::SEL_MODE, 8'h06);
		wr(dtmc_pkg::SEL_T0HI, 8'h10);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		step(1'b1, 1'b0, 3'h0);
		timer0_count_input = 1'b0;
		waitc(6);
		rd(dtmc_pkg::SEL_T0LO, 8'h10);
		timer0_count_input = 1'b1;
		waitc(6); // a rising edge must not count
		rd(dtmc_pkg::SEL_T0LO, 8'h10);
	endtask : sc_source

	task automatic sc_timer1();
		timer0_run = 1'b0;
		timer1_run = 1'b1;
		wr(dtmc_pkg::SEL_MODE, 8'h20);
		wr(dtmc_pkg::SEL_T1HI, 8'h33);
		wr(dtmc_pkg::SEL_T1LO, 8'hff);
		step(1'b0, 1'b1, 3'h3);
		rd(dtmc_pkg::SEL_T1LO, 8'h33);
		wr(dtmc_pkg::SEL_MODE, 8'h30);
		wr(dtmc_pkg::SEL_T1LO, 8'hff);
		step(1'b0, 1'b1, 3'h0);
		rd(dtmc_pkg::SEL_T1LO, 8'hff);
		// timer 1 in counter mode: the tick is ignored, a pin fall reloads
		wr(dtmc_pkg::SEL_MODE, 8'h60);
		wr(dtmc_pkg::SEL_T1HI, 8'h44);
		wr(dtmc_pkg::SEL_T1LO, 8'hff);
		step(1'b0, 1'b1, 3'h0);
		timer1_count_input = 1'b0;
		waitc(6);
		rd(dtmc_pkg::SEL_T1LO, 8'h44);
		timer1_count_input = 1'b1;
		waitc(6);
	endtask : sc_timer1

	task automatic sc_split();
		timer0_run = 1'b1;
		timer1_run = 1'b0;
		wr(dtmc_pkg::SEL_MODE, 8'h23);
		wr(dtmc_pkg::SEL_T0LO, 8'hff);
		wr(dtmc_pkg::SEL_T0HI, 8'hff);
		wr(dtmc_pkg::SEL_T1HI, 8'h07);
		wr(dtmc_pkg::SEL_T1LO, 8'hff);
		step(1'b1, 1'b0, 3'h4);
		rd(dtmc_pkg::SEL_T0HI, 8'hff);
		timer1_run = 1'b1;
		step(1'b1, 1'b0, 3'h2);
		timer1_run = 1'b0;
		step(1'b0, 1'b1, 3'h1);
		rd(dtmc_pkg::SEL_T1LO, 8'h07);
		// source select set during split: ticks still count, pin falls must not
		wr(dtmc_pkg::SEL_MODE, 8'h63);
		step(1'b0, 1'b1, 3'h0);
		timer1_count_input = 1'b0;
		waitc(6);
		rd(dtmc_pkg::SEL_T1LO, 8'h08);
		timer1_count_input = 1'b1;
		waitc(6);
		wr(dtmc_pkg::SEL_MODE, 8'h33);
		wr(dtmc_pkg::SEL_T1LO, 8'hff);
		step(1'b0, 1'b1, 3'h0);
	endtask : sc_split

	// ==========================================
	// verdict and end of run
	task automatic summarize();
		if (fails == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	// watchdog far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		summarize();
	end

	// main sequence, reset held for 12 cycles
	initial begin
		rst = 1'b1;
		sfrWe = 1'b0;
		sfrSel = 3'h0;
		sfrWdata = 8'h00;
		timer0_run = 1'b0;
		timer1_run = 1'b0;
		timer0Tick = 1'b0;
		timer1Tick = 1'b0;
		ext_irq0_pin_n = 1'b1;
		ext_irq1_pin_n = 1'b1;
		timer0_count_input = 1'b1;
		timer1_count_input = 1'b1;
		waitc(12);
		rst = 1'b0;
		sc_regs();
		sc_modes();
		sc_gate();
		sc_source();
		sc_timer1();
		sc_split();
		summarize();
	end
endmodule : tb_top
